// ==== design/aphp_pkg.sv ====
// Shared constants for the converter parallel host port
package aphp_pkg;
  localparam int APHP_DW = 13;
  localparam int APHP_NARROW = 8;
  // Configuration word fields
  localparam int APHP_CH_LSB = 0;
  localparam int APHP_CH_MSB = 3;
  localparam int APHP_SYNC_DIR_BIT = 8;
  localparam int APHP_BW_BIT = 12;
  localparam logic [12:0] APHP_CFG_RST = 13'h0000;
  // Converter timing in clk_sys cycles
  localparam logic [7:0] APHP_CONV_CYCLES = 8'h28;
  localparam logic [7:0] APHP_WAKE_CYCLES = 8'h10;
  // Strobe pulse widths used by the host end
  localparam logic [3:0] APHP_STROBE_CYCLES = 4'h4;
  // Host register byte addresses
  localparam logic [4:0] APHP_A_CTRL = 5'h00;
  localparam logic [4:0] APHP_A_WDATA = 5'h04;
  localparam logic [4:0] APHP_A_RDATA = 5'h08;
  localparam logic [4:0] APHP_A_STATUS = 5'h0c;
  localparam logic [4:0] APHP_A_IRQ = 5'h10;
endpackage

// ==== design/aphp_if.sv ====
// Pin-level carrier between the converter port and its host
`timescale 1ns/1ps
`default_nettype none
interface aphp_if;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic [12:0] data_h2d;
  logic [12:0] data_d2h;
  logic [12:0] data_oe;
  logic sync_d2h;
  logic sync_h2d;
  logic sync_oe;
  logic ready_n;
  logic standby_indicator_n;
  logic write_edge_select;
  modport dev (
    input cs_n, wr_n, rd_n, data_h2d, sync_h2d, write_edge_select,
    output data_d2h, data_oe, sync_d2h, sync_oe, ready_n, standby_indicator_n
  );
  modport host (
    output cs_n, wr_n, rd_n, data_h2d, sync_h2d, write_edge_select,
    input data_d2h, data_oe, sync_d2h, sync_oe, ready_n, standby_indicator_n
  );
endinterface
`default_nettype wire

// ==== design/aphp_device.sv ====
// Converter end of the parallel host port
// Rules the document sets for this port
// RULE_01 - Strap at reset picks write latch edge
// RULE_02 - Host keeps write edge strap constant
// RULE_03 - Config bit 8 sets sync direction
// RULE_04 - Sync input rising edge starts conversion
// RULE_05 - Sync output high during each conversion
// RULE_06 - Config bit 12 selects 8/13 bus
// RULE_07 - Msb on line 12, lsb line 0
// RULE_08 - Host supplies 0.05 to 12 MHz clock; the port carries no clock line, both ends run on clk_sys
// RULE_09 - Data captured only while select and write
// RULE_10 - Bus driven only during select and read; drive follows the synchronised strobes, two clk_sys cycles late
// RULE_11 - Active low ready marks function start/end
// RULE_12 - Standby indicator low only in standby
// RULE_13 - Config bits 3..0 choose mux channels
// RULE_14 - Configuration written by select-write cycle
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module aphp_device
  import aphp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  aphp_if.dev port,
  input wire logic [12:0] conv_result,
  input wire logic standby_req,
  output logic [3:0] selector_chan,
  output logic [12:0] conv_data_out,
  output logic converting
);
  typedef enum logic [1:0] {
    APHP_S_IDLE = 2'b00,
    APHP_S_CONV = 2'b01,
    APHP_S_SLEEP = 2'b10,
    APHP_S_WAKE = 2'b11
  } aphp_state_t;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Strobes come from another chip, so two flops before use
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic [4:0] prev_reg;
  logic [12:0] dmeta_reg;
  logic [12:0] dsync_reg;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      meta_reg <= 5'h07;
      sync_reg <= 5'h07;
      prev_reg <= 5'h07;
      dmeta_reg <= 13'h0000;
      dsync_reg <= 13'h0000;
    end
    else
    begin
      meta_reg <= {port.write_edge_select, port.sync_h2d, port.rd_n, port.wr_n, port.cs_n};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      dmeta_reg <= port.data_h2d;
      dsync_reg <= dmeta_reg;
    end
  end
  wire logic cs_s = sync_reg[0];
  wire logic wr_s = sync_reg[1];
  wire logic rd_s = sync_reg[2];
  wire logic syn_s = sync_reg[3];
  wire logic wes_s = sync_reg[4];

  // ----------------------------------------
  // Strap capture and configuration
  // ----------------------------------------
  logic strap_done_reg, strap_done_next;
  logic edge_fall_reg, edge_fall_next;
  logic [12:0] cfg_reg, cfg_next;
  logic [2:0] stg_reg, stg_next;
  logic wr_edge;
  always_comb
  begin
    stg_next = (stg_reg == 3'h3) ? stg_reg : stg_reg + 3'h1;
    strap_done_next = strap_done_reg;
    edge_fall_next = edge_fall_reg;
    // Wait until the strap has passed the synchroniser
    if (!strap_done_reg && stg_reg == 3'h3)
    begin
      strap_done_next = 1'b1;
      edge_fall_next = wes_s; // RULE_01
    end
    // Latch edge chosen once; later strap moves are ignored
    if (edge_fall_reg)
      wr_edge = prev_reg[1] && !wr_s && !cs_s; // RULE_01 RULE_09
    else
      wr_edge = !prev_reg[1] && wr_s && !prev_reg[0]; // RULE_01 RULE_09
    cfg_next = cfg_reg;
    if (strap_done_reg && wr_edge)
      cfg_next = dsync_reg; // RULE_14
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      stg_reg <= 3'h0;
      strap_done_reg <= 1'b0;
      edge_fall_reg <= 1'b0;
      cfg_reg <= APHP_CFG_RST;
    end
    else
    begin
      stg_reg <= stg_next;
      strap_done_reg <= strap_done_next;
      edge_fall_reg <= edge_fall_next;
      cfg_reg <= cfg_next;
    end
  end
  wire logic sync_is_in = cfg_reg[APHP_SYNC_DIR_BIT]; // RULE_03
  wire logic wide_bus = cfg_reg[APHP_BW_BIT];

  // ----------------------------------------
  // Conversion and standby sequencer
  // ----------------------------------------
  aphp_state_t st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [12:0] res_reg, res_next;
  logic rdy_n_reg, rdy_n_next;
  logic start;
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    res_next = res_reg;
    rdy_n_next = rdy_n_reg;
    // Sync input starts a conversion; as output, a config write does
    start = sync_is_in ? (syn_s && !prev_reg[3]) : (strap_done_reg && wr_edge); // RULE_04
    case (st_reg)
      APHP_S_IDLE:
      begin
        if (standby_req)
          st_next = APHP_S_SLEEP;
        else if (start)
        begin
          st_next = APHP_S_CONV; // RULE_04
          cnt_next = APHP_CONV_CYCLES;
          rdy_n_next = 1'b1; // RULE_11
        end
      end
      APHP_S_CONV:
      begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01)
        begin
          st_next = APHP_S_IDLE;
          res_next = conv_result;
          rdy_n_next = 1'b0; // RULE_11
        end
      end
      APHP_S_SLEEP:
      begin
        if (!standby_req)
        begin
          st_next = APHP_S_WAKE;
          cnt_next = APHP_WAKE_CYCLES;
        end
      end
      default:
      begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01)
          st_next = APHP_S_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_reg <= APHP_S_IDLE;
      cnt_reg <= 8'h00;
      res_reg <= 13'h0000;
      rdy_n_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      res_reg <= res_next;
      rdy_n_reg <= rdy_n_next;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic rd_act;
  assign rd_act = !cs_s && !rd_s; // RULE_10
  assign port.data_d2h = res_reg; // RULE_07
  // Upper lines stay released in narrow mode
  assign port.data_oe = {{5{rd_act && wide_bus}}, {8{rd_act}}}; // RULE_06 RULE_10
  assign port.sync_oe = !sync_is_in; // RULE_03
  assign port.sync_d2h = (st_reg == APHP_S_CONV); // RULE_05
  assign port.ready_n = rdy_n_reg; // RULE_11
  // Wake request lifts the indicator at once
  assign port.standby_indicator_n = !(st_reg == APHP_S_SLEEP && standby_req); // RULE_12
  assign selector_chan = cfg_reg[APHP_CH_MSB:APHP_CH_LSB]; // RULE_13
  assign conv_data_out = res_reg;
  assign converting = (st_reg == APHP_S_CONV);
endmodule
`default_nettype wire

// ==== design/aphp_host.sv ====
// Host end of the parallel port, commanded over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module aphp_host
  import aphp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  aphp_if.host port,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  typedef enum logic [1:0] {
    APHP_H_IDLE = 2'b00,
    APHP_H_WR = 2'b01,
    APHP_H_RD = 2'b10
  } aphp_hstate_t;

  // ----------------------------------------
  // Synchronisers for device pins
  // ----------------------------------------
  logic [1:0] m_reg, s_reg, p_reg;
  logic [12:0] dm_reg, ds_reg;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      // Idle pin levels: standby high, ready low, so no false event
      m_reg <= 2'h2;
      s_reg <= 2'h2;
      p_reg <= 2'h2;
      dm_reg <= 13'h0000;
      ds_reg <= 13'h0000;
    end
    else
    begin
      m_reg <= {port.standby_indicator_n, port.ready_n};
      s_reg <= m_reg;
      p_reg <= s_reg;
      // Released lines read as zero
      dm_reg <= port.data_d2h & port.data_oe;
      ds_reg <= dm_reg;
    end
  end

  // ----------------------------------------
  // Strobe sequencer and registers
  // ----------------------------------------
  aphp_hstate_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [12:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic [1:0] sts_reg, sts_next, msk_reg, msk_next;
  logic done;
  logic [1:0] ev;
  logic [31:0] rdata;
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    ctrl_next = ctrl_reg;
    msk_next = msk_reg;
    done = 1'b0;
    rdata = 32'h0000_0000;
    // Ready falling and standby rising become sticky events; set wins
    ev = {s_reg[1] && !p_reg[1], !s_reg[0] && p_reg[0]};
    sts_next = sts_reg | ev;
    if (avs_address == APHP_A_CTRL)
      rdata = {30'h0, ctrl_reg};
    else if (avs_address == APHP_A_WDATA)
      rdata = {19'h0, wd_reg};
    else if (avs_address == APHP_A_RDATA)
      rdata = {19'h0, rd_reg};
    else if (avs_address == APHP_A_STATUS)
      rdata = {28'h0, s_reg, sts_reg};
    else if (avs_address == APHP_A_IRQ)
      rdata = {30'h0, msk_reg};
    case (st_reg)
      APHP_H_IDLE:
      begin
        if (avs_write && avs_address == APHP_A_WDATA)
        begin
          // RULE_09 RULE_14
          wd_next = avs_writedata[12:0];
          st_next = APHP_H_WR;
          cnt_next = APHP_STROBE_CYCLES;
        end
        else if (avs_read && avs_address == APHP_A_RDATA)
        begin
          st_next = APHP_H_RD; // RULE_10
          cnt_next = APHP_STROBE_CYCLES;
        end
        else if (avs_read || avs_write)
        begin
          done = 1'b1;
          if (avs_write && avs_address == APHP_A_CTRL)
            ctrl_next = avs_writedata[1:0];
          // A fresh event in the clearing cycle survives
          if (avs_write && avs_address == APHP_A_STATUS)
            sts_next = (sts_reg & ~avs_writedata[1:0]) | ev;
          if (avs_write && avs_address == APHP_A_IRQ)
            msk_next = avs_writedata[1:0];
        end
      end
      default:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0)
        begin
          done = 1'b1;
          st_next = APHP_H_IDLE;
          if (st_reg == APHP_H_RD)
          begin
            rd_next = ds_reg;
            rdata = {19'h0, ds_reg};
          end
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_reg <= APHP_H_IDLE;
      cnt_reg <= 4'h0;
      wd_reg <= 13'h0000;
      rd_reg <= 13'h0000;
      ctrl_reg <= 2'h0;
      sts_reg <= 2'h0;
      msk_reg <= 2'h0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      ctrl_reg <= ctrl_next;
      sts_reg <= sts_next;
      msk_reg <= msk_next;
    end
  end

  // Data held through the whole strobe and after it, until the next data write
  assign port.cs_n = (st_reg == APHP_H_IDLE) || cnt_reg == 4'h0; // RULE_09 RULE_10
  assign port.wr_n = !(st_reg == APHP_H_WR && cnt_reg != 4'h0); // RULE_09
  assign port.rd_n = !(st_reg == APHP_H_RD && cnt_reg != 4'h0); // RULE_10
  assign port.data_h2d = wd_reg;
  assign port.sync_h2d = ctrl_reg[0];
  assign port.write_edge_select = ctrl_reg[1]; // RULE_02
  assign avs_waitrequest = (avs_read || avs_write) && !done;
  assign avs_readdata = rdata;
  assign irq = |(sts_reg & msk_reg);
endmodule
`default_nettype wire

// ==== testbench/aphp_asserts.sv ====
// Pin-level checks on the converter port carrier
`timescale 1ns/1ps
`default_nettype none
module aphp_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic sync_h2d,
  input wire logic sync_d2h,
  input wire logic sync_oe,
  input wire logic ready_n,
  input wire logic [12:0] data_oe
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence wr_pulse_s;
    (!wr_n && !cs_n) [*4] ##1 wr_n;
  endsequence
  // Drive may trail the read window by the 2-flop sync lag
  sequence rd_win_s;
    (!cs_n && !rd_n) || $past(!cs_n && !rd_n, 1) || $past(!cs_n && !rd_n, 2)
      || $past(!cs_n && !rd_n, 3);
  endsequence
  strobe_excl_a: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes low together");
  wr_width_a: assert property ($fell(wr_n) |-> wr_pulse_s)
    else $error("write strobe pulse malformed");
  oe_read_a: assert property (|data_oe |-> rd_win_s)
    else $error("data driven outside a read");
  oe_write_a: assert property ((!cs_n && !wr_n) [*3] |-> data_oe == 13'h0000)
    else $error("data driven during a write");
  oe_lanes_a: assert property (|data_oe |-> data_oe[7:0] == 8'hff)
    else $error("lane enables split");
  sync_len_a: assert property (sync_oe && $rose(sync_d2h) |-> sync_d2h [*8])
    else $error("sync output pulse too short");
  sync_end_a: assert property (sync_oe && $fell(sync_d2h) |-> ##[0:2] !ready_n)
    else $error("sync fell without completion");
  sync_in_a: assert property (!sync_oe && $rose(sync_h2d) && !ready_n |-> ##[1:5] ready_n)
    else $error("sync input edge started nothing");
  ready_hold_a: assert property ($rose(ready_n) |-> ready_n [*8])
    else $error("busy indication too short");
endmodule
`default_nettype wire

// ==== testbench/adc_parallel_host_port_tb_top.sv ====
// Self-checking bench: host and converter ends joined by the carrier
`timescale 1ns/1ps
`default_nettype none
module adc_parallel_host_port_tb_top;
  logic clk_sys, rst_n, dev_rst_n, standby_req, avs_read, avs_write, avs_waitrequest;
  logic converting, irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_q;
  logic [12:0] conv_result, conv_data_out;
  logic [3:0] selector_chan;
  int fail_count, checks_done;
  // ----------------------------------------
  // Structure
  // ----------------------------------------
  aphp_if bus ();
  aphp_device aphp_device_inst (.clk_sys(clk_sys), .rst_n(dev_rst_n), .port(bus),
    .conv_result(conv_result), .standby_req(standby_req), .selector_chan(selector_chan),
    .conv_data_out(conv_data_out), .converting(converting));
  aphp_host aphp_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .port(bus),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  aphp_asserts aphp_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n & dev_rst_n),
    .cs_n(bus.cs_n), .wr_n(bus.wr_n), .rd_n(bus.rd_n), .sync_h2d(bus.sync_h2d),
    .sync_d2h(bus.sync_d2h), .sync_oe(bus.sync_oe), .ready_n(bus.ready_n),
    .data_oe(bus.data_oe));
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Waitrequest and read data taken at the same rising edge
  task av_ack;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd_q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task av_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    av_ack;
  endtask
  task av_rd(input logic [4:0] a);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    av_ack;
  endtask
  task t_narrow;
    conv_result <= 13'h1abc;
    av_wr(5'h04, 32'h0000_0005);
    // Rising latch lands two sync stages after the strobe ends
    repeat (3) @(posedge clk_sys);
    check(selector_chan, 4'h5);
    repeat (5) @(posedge clk_sys);
    check(bus.sync_d2h, 1'b1);
    check(bus.ready_n, 1'b1);
    repeat (50) @(posedge clk_sys);
    check(bus.sync_d2h, 1'b0);
    check(bus.ready_n, 1'b0);
    check(conv_data_out, 13'h1abc);
    av_rd(5'h08);
    check(rd_q[7:0], 8'hbc);
    check(rd_q[12:8], 5'h00);
    $display("narrow bus test done");
  endtask
  task t_wide;
    conv_result <= 13'h0a53;
    av_wr(5'h04, 32'h0000_1003);
    repeat (3) @(posedge clk_sys);
    check(selector_chan, 4'h3);
    repeat (50) @(posedge clk_sys);
    av_rd(5'h08);
    check(rd_q[12:0], 13'h0a53);
    av_rd(5'h14);
    check(rd_q, 32'h0);
    av_wr(5'h10, 32'h1);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b1);
    av_wr(5'h0c, 32'h1);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b0);
    av_wr(5'h10, 32'h0);
    $display("wide bus and irq test done");
  endtask
  task t_sync_in;
    av_wr(5'h04, 32'h0000_1102);
    repeat (50) @(posedge clk_sys);
    check(bus.sync_oe, 1'b0);
    av_wr(5'h00, 32'h1);
    repeat (6) @(posedge clk_sys);
    check(converting, 1'b1);
    repeat (50) @(posedge clk_sys);
    av_wr(5'h00, 32'h0);
    $display("sync input test done");
  endtask
  task t_standby;
    standby_req <= 1'b1;
    repeat (40) @(posedge clk_sys);
    check(bus.standby_indicator_n, 1'b0);
    standby_req <= 1'b0;
    // Still asleep this cycle: only the request lifts the indicator
    @(posedge clk_sys);
    check(bus.standby_indicator_n, 1'b1);
    av_wr(5'h10, 32'h2);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b1);
    av_wr(5'h0c, 32'h2);
    av_rd(5'h0c);
    check(rd_q[1], 1'b0);
    check(irq, 1'b0);
    $display("standby test done");
  endtask
  // Strap only counts at release of the converter's reset
  task t_falling;
    av_wr(5'h00, 32'h2);
    dev_rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    dev_rst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    av_wr(5'h04, 32'h0000_0007);
    check(selector_chan, 4'h7);
    repeat (50) @(posedge clk_sys);
    $display("falling edge latch test done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    dev_rst_n = 1'b0;
    standby_req = 1'b0;
    conv_result = 13'h0000;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    dev_rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    t_narrow;
    t_wide;
    t_sync_in;
    t_standby;
    t_falling;
    tally_and_finish;
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
